/* File: lact_pkg.sv */
package lact_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 4;
    localparam int unsigned IN_ACK_LAT_CYC   = 1;
    localparam int unsigned OUT_TRIG_LAT_CYC = 9;
    // the output flop adds one cycle after the delay line
    localparam int unsigned DLY_DEPTH        = OUT_TRIG_LAT_CYC - 1;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic RST_TRIG_OUT    = 1'h0;
    localparam logic RST_TRIG_IN_ACK = 1'h0;
    localparam logic RST_TRIG_IN_Q   = 1'h0;

    // ------------------------------------------------------------------
    // cross-trigger state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_ARMED = 2'h0,
        ST_DELAY = 2'h1,
        ST_HIGH  = 2'h2,
        ST_DONE  = 2'h3
    } lact_state_t;

endpackage

/* File: lact_dly_if.sv */
`timescale 1ns/100ps
interface lact_dly_if;
    logic start;
    logic clear;
    logic done;

    modport ctrl (
        output start,
        output clear,
        input  done
    );

    modport line (
        input  start,
        input  clear,
        output done
    );
endinterface

/* File: lact_dly_line.sv */
`timescale 1ns/100ps
module lact_dly_line
    import lact_pkg::*;
#(
    parameter int unsigned DEPTH = DLY_DEPTH
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    lact_dly_if.line  dly
);

    logic [DEPTH-1:0] pipe_ff;

    // ------------------------------------------------------------------
    // event shift line
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i || dly.clear) begin
            pipe_ff <= '0;
        end else begin
            pipe_ff <= {pipe_ff[DEPTH-2:0], dly.start};
        end
    end

    assign dly.done = pipe_ff[DEPTH-1];

endmodule

/* File: lact_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - trigger out held until acknowledge arrives
// - ack tied low: out held until re-arm
// - re-arm allowed while acknowledge stays low
// - input ack rises one cycle after input
// - trigger out rises nine cycles after cause
// - acks fall only after their trigger falls
// - out feeds far input, far ack feeds ours
// - input and output pairs enabled by parameter
module lact_top
    import lact_pkg::*;
#(
    parameter bit TRIG_IN_EN  = 1'b1,
    parameter bit TRIG_OUT_EN = 1'b1
) (
    input  wire logic CLK_I,
    input  wire logic RSTN_I,
    input  wire logic TRIG_IN_I,
    output logic      TRIG_IN_ACK_O,
    output logic      TRIG_OUT_O,
    input  wire logic TRIG_OUT_ACK_I,
    input  wire logic TRIG_COND_I,
    input  wire logic REARM_I
);

    // ------------------------------------------------------------------
    // trigger state
    // ------------------------------------------------------------------
    lact_state_t state_ff;
    lact_state_t nxt_state;
    logic        armed;

    // ------------------------------------------------------------------
    // input trigger path
    // ------------------------------------------------------------------
    logic        trig_in_use;
    logic        trig_in_q_ff;
    logic        nxt_trig_in_q;
    logic        trig_in_ack_ff;
    logic        nxt_trig_in_ack;
    logic        in_rise;

    // ------------------------------------------------------------------
    // output trigger path
    // ------------------------------------------------------------------
    logic        trig_ack_use;
    logic        out_allow;
    logic        trig_out_ff;
    logic        nxt_trig_out;
    logic        cause_in;
    logic        cause_cond;
    logic        cause;

    lact_dly_if dly ();

    // ------------------------------------------------------------------
    // optional port pairs
    // ------------------------------------------------------------------
    // a disabled pair reads as idle
    generate
        if (TRIG_IN_EN) begin : g_trig_in
            assign trig_in_use = TRIG_IN_I;
        end else begin : g_no_trig_in
            assign trig_in_use = 1'h0;
        end

        if (TRIG_OUT_EN) begin : g_trig_out
            assign trig_ack_use = TRIG_OUT_ACK_I;
            assign out_allow    = 1'h1;
        end else begin : g_no_trig_out
            assign trig_ack_use = 1'h0;
            assign out_allow    = 1'h0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // trigger causes
    // ------------------------------------------------------------------
    // re-arm in the same cycle drops the cause
    assign armed      = (state_ff == ST_ARMED);
    assign in_rise    = trig_in_use & ~trig_in_q_ff;
    assign cause_in   = armed & ~REARM_I & in_rise;
    assign cause_cond = armed & ~REARM_I & TRIG_COND_I;
    assign cause      = cause_in | cause_cond;

    // ------------------------------------------------------------------
    // input trigger handshake
    // ------------------------------------------------------------------
    always_comb begin
        nxt_trig_in_q   = trig_in_use;
        nxt_trig_in_ack = trig_in_use;
    end

    // edge memory for the rising-edge cause
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            trig_in_q_ff <= RST_TRIG_IN_Q;
        end else begin
            trig_in_q_ff <= nxt_trig_in_q;
        end
    end

    // ack follows the input one cycle late, so it falls only after it
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            trig_in_ack_ff <= RST_TRIG_IN_ACK;
        end else begin
            trig_in_ack_ff <= nxt_trig_in_ack;
        end
    end

    // ------------------------------------------------------------------
    // output trigger delay
    // ------------------------------------------------------------------
    assign dly.start = cause;
    assign dly.clear = REARM_I;

    // ------------------------------------------------------------------
    // delay line
    // ------------------------------------------------------------------
    // cleared on re-arm so a cancelled trigger never fires
    lact_dly_line #(
        .DEPTH (DLY_DEPTH)
    ) u_dly (
        .clk_i  (CLK_I),
        .rstn_i (RSTN_I),
        .dly    (dly)
    );

    // ------------------------------------------------------------------
    // trigger state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_ARMED: begin
                if (cause) begin
                    nxt_state = ST_DELAY;
                end
            end
            // wait out the fixed latency
            ST_DELAY: begin
                if (dly.done) begin
                    nxt_state = ST_HIGH;
                end
            end
            // hold until the far side acknowledges
            ST_HIGH: begin
                if (trig_ack_use) begin
                    nxt_state = ST_DONE;
                end
            end
            // one trigger per arm: wait here for re-arm
            ST_DONE: begin
                nxt_state = ST_DONE;
            end
            default: begin
                nxt_state = ST_ARMED;
            end
        endcase
        // re-arm wins over every state and cancels a pending trigger
        if (REARM_I) begin
            nxt_state = ST_ARMED;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            state_ff <= ST_ARMED;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // output trigger
    // ------------------------------------------------------------------
    // raised on entry to the high state, dropped on ack or re-arm
    always_comb begin
        nxt_trig_out = 1'h0;
        case (nxt_state)
            ST_HIGH: begin
                nxt_trig_out = out_allow;
            end
            ST_ARMED: begin
                nxt_trig_out = 1'h0;
            end
            ST_DELAY: begin
                nxt_trig_out = 1'h0;
            end
            ST_DONE: begin
                nxt_trig_out = 1'h0;
            end
            default: begin
                nxt_trig_out = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // output register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            trig_out_ff <= RST_TRIG_OUT;
        end else begin
            trig_out_ff <= nxt_trig_out;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign TRIG_IN_ACK_O = trig_in_ack_ff;
    assign TRIG_OUT_O    = trig_out_ff;

endmodule

/* File: lact_top_assertions.sv */
`timescale 1ns/100ps
module lact_top_chk #(
    parameter bit IN_EN  = 1'h1,
    parameter bit OUT_EN = 1'h1
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic TRIG_IN_I,
    input wire logic TRIG_IN_ACK_O,
    input wire logic TRIG_OUT_O,
    input wire logic TRIG_OUT_ACK_I,
    input wire logic TRIG_COND_I,
    input wire logic REARM_I
);
    // ---------------
    // checks
    // ---------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence s_quiet;
        !TRIG_OUT_O [*8];
    endsequence
    a_in_ack_rise:
        assert property (IN_EN && TRIG_IN_I |=> TRIG_IN_ACK_O) else $error("input ack late");
    a_in_pair_off:
        assert property (!IN_EN |-> !TRIG_IN_ACK_O) else $error("disabled input ack raised");
    a_out_pair_off:
        assert property (!OUT_EN |-> !TRIG_OUT_O) else $error("disabled output raised");
    a_in_ack_fall:
        assert property (!TRIG_IN_I |=> !TRIG_IN_ACK_O) else $error("input ack stuck");
    a_out_cause_delay:
        assert property ($rose(TRIG_OUT_O) |-> ($past(TRIG_COND_I, 9) && !$past(REARM_I, 9))
            || ($past(TRIG_IN_I, 9) && !$past(REARM_I, 9) && !$past(TRIG_IN_I, 10)))
            else $error("output trigger without cause");
    a_out_hold:
        assert property (TRIG_OUT_O && !TRIG_OUT_ACK_I && !REARM_I |=> TRIG_OUT_O)
            else $error("output trigger dropped");
    a_out_ack_drop:
        assert property (TRIG_OUT_O && TRIG_OUT_ACK_I |=> !TRIG_OUT_O)
            else $error("output trigger kept after ack");
    a_out_rearm_drop:
        assert property (TRIG_OUT_O && REARM_I |=> !TRIG_OUT_O)
            else $error("output trigger kept after rearm");
    a_rearm_quiet:
        assert property (REARM_I |=> s_quiet) else $error("trigger too soon");
    a_fall_quiet:
        assert property ($fell(TRIG_OUT_O) |-> s_quiet) else $error("retrigger too soon");
endmodule
bind lact_top lact_top_chk #(.IN_EN(TRIG_IN_EN), .OUT_EN(TRIG_OUT_EN)) chk (.CLK_I(CLK_I),
    .RSTN_I(RSTN_I), .TRIG_IN_I(TRIG_IN_I), .TRIG_IN_ACK_O(TRIG_IN_ACK_O),
    .TRIG_OUT_O(TRIG_OUT_O), .TRIG_OUT_ACK_I(TRIG_OUT_ACK_I), .TRIG_COND_I(TRIG_COND_I),
    .REARM_I(REARM_I));

/* File: lact_far.sv */
`timescale 1ns/100ps
module lact_far (
    input  wire logic clk_i,
    input  wire logic en_i,
    input  wire logic trig_i,
    output logic      ack_o
);
    // ack follows the trigger one cycle late, falls after it falls
    always_ff @(posedge clk_i) begin
        ack_o <= en_i & trig_i;
    end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    logic clk, rst_n, tin, tack, tout, oack, cond, rearm, en;
    logic tack_off, tout_off;
    int   n_errors = 0;
    int   comparisons = 0;
    lact_top dut (.CLK_I(clk), .RSTN_I(rst_n), .TRIG_IN_I(tin), .TRIG_IN_ACK_O(tack),
        .TRIG_OUT_O(tout), .TRIG_OUT_ACK_I(oack), .TRIG_COND_I(cond), .REARM_I(rearm));
    lact_top #(.TRIG_IN_EN(1'h0), .TRIG_OUT_EN(1'h0)) dut_off (.CLK_I(clk), .RSTN_I(rst_n),
        .TRIG_IN_I(tin), .TRIG_IN_ACK_O(tack_off), .TRIG_OUT_O(tout_off),
        .TRIG_OUT_ACK_I(oack), .TRIG_COND_I(cond), .REARM_I(rearm));
    lact_far far (.clk_i(clk), .en_i(en), .trig_i(tout), .ack_o(oack));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task check(input logic s, input logic e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task print_verdict;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // input trigger, acked output trigger
    task t_in_path;
        tin = 1'h1;
        cyc(1);
        check(tack, 1'h1);
        check(tack_off, 1'h0);
        tin = 1'h0;
        cyc(1);
        check(tack, 1'h0);
        cyc(6);
        check(tout, 1'h0);
        cyc(1);
        check(tout, 1'h1);
        check(tout_off, 1'h0);
        cyc(1);
        check(tout, 1'h1);
        cyc(1);
        check(tout, 1'h0);
        rearm = 1'h1;
        cyc(1);
        rearm = 1'h0;
    endtask
    // ack tied low, then a cancelled trigger
    task t_tied_low;
        en = 1'h0;
        cond = 1'h1;
        cyc(1);
        cond = 1'h0;
        cyc(7);
        check(tout, 1'h0);
        cyc(1);
        check(tout, 1'h1);
        check(tout_off, 1'h0);
        cyc(20);
        check(tout, 1'h1);
        rearm = 1'h1;
        cyc(1);
        rearm = 1'h0;
        check(tout, 1'h0);
        cond = 1'h1;
        cyc(1);
        cond = 1'h0;
        cyc(3);
        rearm = 1'h1;
        cyc(1);
        rearm = 1'h0;
        cyc(12);
        check(tout, 1'h0);
    endtask
    initial begin
        {tin, cond, rearm, rst_n} = 4'h0;
        en = 1'h1;
        cyc(2);
        rst_n = 1'h1;
        check(tout, 1'h0);
        check(tack, 1'h0);
        t_in_path;
        t_tied_low;
        print_verdict;
    end
    initial begin
        #2000;
        n_errors++;
        print_verdict;
    end
endmodule
